// ---- rtl/slfc_regs.vh ----
`ifndef SLFC_REGS_VH
`define SLFC_REGS_VH
// Operation
// - Latch data, blank, waveform, contrast at frame
// - Enable starts; clear stops at once
// - Waveform change applies at next frame; here at the next data latch, up to two frames away in low power
// - Flag set with data latch at frame
// - Flag cleared by vector or writing one
// - Request needs flag, enable, global enable
// - Low power: latch every second frame
// - Blank after frame: all pins ground
// - Unused bits read zero, ignore writes
// - Clock select: system or asynchronous source
// - Async source: crystal or external clock
// - Bias bit: third or half, static excepted
// - Duty field sets used commons
// - Mask field sets driven segment count
// - Masked segments stay port pins
// - Ripple prescaler then divide one to eight
// - Frame is K times N times D
// - Set bit drives segment opposite phase

// ==========================================
// Register offsets
`define SLFC_ADDR_CTRL_A 5'h00
`define SLFC_ADDR_CTRL_B 5'h01
`define SLFC_ADDR_FRAME 5'h02
`define SLFC_ADDR_CONTR 5'h03
`define SLFC_ADDR_MEM 5'h08
`define SLFC_ADDR_MEM_END 5'h1b

// ==========================================
// Field positions
`define SLFC_A_EN 7
`define SLFC_A_LP 6
`define SLFC_A_FLAG 4
`define SLFC_A_IE 3
`define SLFC_A_BL 0
`define SLFC_B_CS 7
`define SLFC_B_HB 6
`define SLFC_B_MUX 5:4
`define SLFC_B_PM 2:0
`define SLFC_F_PS 6:4
`define SLFC_F_CD 2:0
`define SLFC_C_DC 7:5
`define SLFC_C_CC 3:0

// ==========================================
// Writable masks and reset values
`define SLFC_MASK_A 8'hc9
`define SLFC_MASK_B 8'hf7
`define SLFC_MASK_F 8'h77
`define SLFC_MASK_C 8'hef
`define SLFC_RESET 8'h00

// ==========================================
// Duty codes and frame lengths
`define SLFC_DUTY_STATIC 2'h0
`define SLFC_DUTY_HALF 2'h1
`define SLFC_DUTY_THIRD 2'h2
`define SLFC_K8_LAST 3'h7
`define SLFC_K6_LAST 3'h5
`define SLFC_BIAS_STATIC 2'h0
`define SLFC_BIAS_THIRD 2'h1
`define SLFC_BIAS_HALF 2'h2
`endif

// ---- rtl/slfc_core.v ----
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "slfc_regs.vh"
module slfc_core #(
   parameter MEM_BYTES = 20
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register port
   input wire [4:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Clock sources
   input wire timer_osc_input_pin,
   input wire ext_clock_in,
   input wire external_clock_input_enable,
   // Processor interrupt
   input wire global_irq_enable,
   input wire irq_ack,
   output reg frame_irq,
   // Display pins
   output reg [3:0] common_pin_oe,
   output reg [3:0] common_pin_addr,
   output reg [24:0] segment_pin_oe,
   output reg [24:0] segment_pin_level,
   output reg drive_phase,
   output reg [1:0] bias_mode,
   output reg [3:0] contrast_level,
   output reg [2:0] drive_time_sel,
   output reg blank_active
);

   // ==========================================
   // Functions
   function [11:0] slfc_tap_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: slfc_tap_mask = 12'h00f;
            3'h1: slfc_tap_mask = 12'h03f;
            3'h2: slfc_tap_mask = 12'h07f;
            3'h3: slfc_tap_mask = 12'h0ff;
            3'h4: slfc_tap_mask = 12'h1ff;
            3'h5: slfc_tap_mask = 12'h3ff;
            3'h6: slfc_tap_mask = 12'h7ff;
            default: slfc_tap_mask = 12'hfff;
         endcase
      end
   endfunction

   function [4:0] slfc_seg_count;
      input [2:0] pm;
      begin
         case (pm)
            3'h0: slfc_seg_count = 5'h0d;
            3'h1: slfc_seg_count = 5'h0f;
            3'h2: slfc_seg_count = 5'h11;
            3'h3: slfc_seg_count = 5'h13;
            3'h4: slfc_seg_count = 5'h15;
            3'h5: slfc_seg_count = 5'h17;
            3'h6: slfc_seg_count = 5'h18;
            default: slfc_seg_count = 5'h19;
         endcase
      end
   endfunction

   // ==========================================
   // State
   reg [7:0] ctrl_a;
   reg [7:0] ctrl_b;
   reg [7:0] frame_rate_control;
   reg [7:0] contrast_drive_control;
   reg frame_start_flag;
   reg [7:0] display_memory_byte [0:MEM_BYTES-1];
   reg [7:0] mem_latched [0:MEM_BYTES-1];
   reg sync1, sync2, sync3;
   reg run;
   reg [11:0] ripple;
   reg [2:0] fine_cnt;
   reg [2:0] phase;
   reg parity;
   reg lp_act, blank_act;
   reg [3:0] cc_act;
   reg [2:0] dc_act;
   integer i, j, k;

   wire display_enable = ctrl_a[`SLFC_A_EN];
   wire low_power_wave_select = ctrl_a[`SLFC_A_LP];
   wire frame_irq_enable = ctrl_a[`SLFC_A_IE];
   wire blank_display = ctrl_a[`SLFC_A_BL];
   wire async_clock_select = ctrl_b[`SLFC_B_CS];
   wire half_bias_select = ctrl_b[`SLFC_B_HB];
   wire [1:0] duty_select = ctrl_b[`SLFC_B_MUX];
   wire [2:0] segment_pin_mask = ctrl_b[`SLFC_B_PM];
   wire [2:0] prescale_tap_select = frame_rate_control[`SLFC_F_PS];
   wire [2:0] fine_clock_divide = frame_rate_control[`SLFC_F_CD];

   // ==========================================
   // Clock source and prescaler
   // Async source pick
   wire async_src = external_clock_input_enable ? ext_clock_in :
                    timer_osc_input_pin;
   wire lcd_tick = async_clock_select ? (sync2 & ~sync3) : 1'b1;
   wire [11:0] tap = slfc_tap_mask(prescale_tap_select);
   wire tap_hit = lcd_tick && ((ripple & tap) == tap);
   wire ps_tick = tap_hit && (fine_cnt == fine_clock_divide);
   wire [2:0] k_last = (duty_select == `SLFC_DUTY_THIRD) ?
                       `SLFC_K6_LAST : `SLFC_K8_LAST;
   wire frame_start = display_enable &&
                      (!run || (ps_tick && phase == k_last));
   // Every second frame in low power
   wire latch_evt = frame_start && (!lp_act || !parity);

   // ==========================================
   // Register port decode
   wire mem_hit = (reg_addr >= `SLFC_ADDR_MEM) &&
                  (reg_addr <= `SLFC_ADDR_MEM_END);
   wire [4:0] mem_idx = reg_addr - `SLFC_ADDR_MEM;
   wire wr_a = reg_wr && reg_addr == `SLFC_ADDR_CTRL_A;
   wire flag_clr = (wr_a && reg_wdata[`SLFC_A_FLAG]) || irq_ack;

   reg [7:0] rd_value;
   always @* begin
      rd_value = 8'h00;
      case (reg_addr)
         `SLFC_ADDR_CTRL_A: rd_value = {ctrl_a[7:5], frame_start_flag,
                                        ctrl_a[3:0]};
         `SLFC_ADDR_CTRL_B: rd_value = ctrl_b;
         `SLFC_ADDR_FRAME: rd_value = frame_rate_control;
         `SLFC_ADDR_CONTR: rd_value = contrast_drive_control;
         default: begin
            if (mem_hit) begin
               rd_value = display_memory_byte[mem_idx];
            end
         end
      endcase
   end

   // ==========================================
   // Registers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_a <= `SLFC_RESET;
         ctrl_b <= `SLFC_RESET;
         frame_rate_control <= `SLFC_RESET;
         contrast_drive_control <= `SLFC_RESET;
         frame_start_flag <= 1'b0;
         reg_rdata <= 8'h00;
         for (i = 0; i < MEM_BYTES; i = i + 1) begin
            display_memory_byte[i] <= 8'h00;
         end
      end else begin
         reg_rdata <= reg_rd ? rd_value : 8'h00;
         if (wr_a) begin
            ctrl_a <= reg_wdata & `SLFC_MASK_A;
         end
         if (reg_wr && reg_addr == `SLFC_ADDR_CTRL_B) begin
            ctrl_b <= reg_wdata & `SLFC_MASK_B;
         end
         if (reg_wr && reg_addr == `SLFC_ADDR_FRAME) begin
            frame_rate_control <= reg_wdata & `SLFC_MASK_F;
         end
         if (reg_wr && reg_addr == `SLFC_ADDR_CONTR) begin
            contrast_drive_control <= reg_wdata & `SLFC_MASK_C;
         end
         if (reg_wr && mem_hit) begin
            display_memory_byte[mem_idx] <= reg_wdata;
         end
         if (latch_evt) begin
            frame_start_flag <= 1'b1;
         end else if (flag_clr) begin
            frame_start_flag <= 1'b0;
         end
      end
   end

   // ==========================================
   // Async clock synchroniser
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= async_src;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // ==========================================
   // Frame engine
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         run <= 1'b0;
         ripple <= 12'h000;
         fine_cnt <= 3'h0;
         phase <= 3'h0;
         parity <= 1'b0;
         lp_act <= 1'b0;
         blank_act <= 1'b0;
         cc_act <= 4'h0;
         dc_act <= 3'h0;
         for (j = 0; j < MEM_BYTES; j = j + 1) begin
            mem_latched[j] <= 8'h00;
         end
      end else if (!display_enable) begin
         run <= 1'b0;
         ripple <= 12'h000;
         fine_cnt <= 3'h0;
         phase <= 3'h0;
         parity <= 1'b0;
      end else begin
         run <= 1'b1;
         if (lcd_tick) begin
            ripple <= ripple + 12'h001;
         end
         if (ps_tick) begin
            fine_cnt <= 3'h0;
         end else if (tap_hit) begin
            fine_cnt <= fine_cnt + 3'h1;
         end
         if (frame_start) begin
            phase <= 3'h0;
         end else if (ps_tick) begin
            phase <= phase + 3'h1;
         end
         if (frame_start) begin
            parity <= latch_evt;
         end
         if (latch_evt) begin
            lp_act <= low_power_wave_select;
            blank_act <= blank_display;
            cc_act <= contrast_drive_control[`SLFC_C_CC];
            dc_act <= contrast_drive_control[`SLFC_C_DC];
            for (j = 0; j < MEM_BYTES; j = j + 1) begin
               mem_latched[j] <= display_memory_byte[j];
            end
         end
      end
   end

   // ==========================================
   // Pin drive
   // Common slot per duty
   reg [1:0] com_idx;
   always @* begin
      case (duty_select)
         `SLFC_DUTY_STATIC: com_idx = 2'h0;
         `SLFC_DUTY_HALF: com_idx = {1'b0, phase[2]};
         default: com_idx = phase[2:1];
      endcase
   end

   wire [4:0] base = {3'h0, com_idx} * 5'h05;
   wire [24:0] seg_bits = {mem_latched[base + 5'h03][0],
                           mem_latched[base + 5'h02],
                           mem_latched[base + 5'h01],
                           mem_latched[base]};
   wire wave_ph = lp_act ? parity : phase[0];
   wire [4:0] seg_cnt = slfc_seg_count(segment_pin_mask);
   reg [24:0] seg_en;
   reg [3:0] com_en;
   always @* begin
      for (k = 0; k < 25; k = k + 1) begin
         seg_en[k] = (k < seg_cnt);
      end
      for (k = 0; k < 4; k = k + 1) begin
         com_en[k] = (k <= duty_select);
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         common_pin_oe <= 4'h0;
         common_pin_addr <= 4'h0;
         segment_pin_oe <= 25'h0000000;
         segment_pin_level <= 25'h0000000;
         drive_phase <= 1'b0;
         bias_mode <= `SLFC_BIAS_STATIC;
         contrast_level <= 4'h0;
         drive_time_sel <= 3'h0;
         blank_active <= 1'b0;
         frame_irq <= 1'b0;
      end else begin
         frame_irq <= frame_start_flag && frame_irq_enable &&
                      global_irq_enable;
         contrast_level <= cc_act;
         drive_time_sel <= dc_act;
         if (duty_select == `SLFC_DUTY_STATIC) begin
            bias_mode <= `SLFC_BIAS_STATIC;
         end else begin
            bias_mode <= half_bias_select ? `SLFC_BIAS_HALF :
                         `SLFC_BIAS_THIRD;
         end
         segment_pin_oe <= (display_enable && run) ? seg_en :
                           25'h0000000;
         common_pin_oe <= (display_enable && run) ? com_en : 4'h0;
         blank_active <= display_enable && run && blank_act;
         if (!display_enable || !run || blank_act) begin
            common_pin_addr <= 4'h0;
            drive_phase <= 1'b0;
            segment_pin_level <= 25'h0000000;
         end else begin
            common_pin_addr <= (4'h1 << com_idx) & com_en;
            drive_phase <= wave_ph;
            segment_pin_level <= (seg_bits ^ {25{wave_ph}}) & seg_en;
         end
      end
   end

endmodule // slfc_core

// ---- tb/slfc_glass.sv ----
`timescale 1ns/1ps
module slfc_glass (
   // Clock
   input wire mclk,
   // Display pins
   input wire [3:0] common_pin_addr,
   input wire [24:0] segment_pin_oe,
   input wire [24:0] segment_pin_level,
   // Observations
   output reg [7:0] frames_seen = 8'h00,
   output reg [7:0] bad_drive = 8'h00
);
   // ==========================================
   // Passive glass: counts cycles with common 0 addressed, flags stray drive
   always @(posedge mclk) begin
      if (common_pin_addr == 4'h1 && frames_seen != 8'hff)
         frames_seen <= frames_seen + 8'h01;
      if ((segment_pin_level & ~segment_pin_oe) != 25'h0)
         bad_drive <= bad_drive + 8'h01;
   end
endmodule // slfc_glass

// ---- tb/slfc_monitor.sv ----
`timescale 1ns/1ps
module slfc_monitor (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register port
   input wire [4:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Interrupt
   input wire global_irq_enable,
   input wire frame_irq,
   // Display pins
   input wire [3:0] common_pin_oe,
   input wire [3:0] common_pin_addr,
   input wire [24:0] segment_pin_oe,
   input wire [24:0] segment_pin_level,
   input wire [1:0] bias_mode,
   input wire blank_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================
   // Sequences
   sequence s_off;
      reg_wr && reg_addr == 5'h00 && !reg_wdata[7];
   endsequence
   sequence s_pins_free;
      common_pin_oe == 4'h0 && segment_pin_oe == 25'h0;
   endsequence
   // ==========================================
   // Assertions
   AST_OFF_AT_ONCE: assert property (
      s_off |-> ##[1:3] s_pins_free)
      else $error("pins still owned after disable");
   AST_RD_IDLE: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property (
      reg_rd && reg_addr inside {[5'h04:5'h07]} |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_A_RESERVED: assert property (
      reg_rd && reg_addr == 5'h00 |=> (reg_rdata & 8'h26) == 8'h00)
      else $error("reserved bits of A read one");
   AST_IRQ_GATE: assert property (
      frame_irq |-> $past(global_irq_enable))
      else $error("request without global enable");
   AST_COM_OE: assert property (
      common_pin_oe inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
      else $error("bad common ownership");
   AST_SEG_OE: assert property (
      segment_pin_oe inside {25'h0, 25'h1fff, 25'h7fff, 25'h1ffff,
      25'h7ffff, 25'h1fffff, 25'h7fffff, 25'hffffff, 25'h1ffffff})
      else $error("bad segment ownership");
   AST_SEG_MASKED: assert property (
      (segment_pin_level & ~segment_pin_oe) == 25'h0)
      else $error("masked segment driven");
   AST_ADDR_OWNED: assert property (
      $onehot0(common_pin_addr)
      && (common_pin_addr & ~common_pin_oe) == 4'h0)
      else $error("addressed common not owned");
   AST_BLANK_GND: assert property (
      blank_active
      |-> segment_pin_level == 25'h0 && common_pin_addr == 4'h0)
      else $error("blanked pins not grounded");
   AST_STATIC_BIAS: assert property (
      common_pin_oe == 4'h1 |-> bias_mode == 2'h0)
      else $error("static duty without static bias");
endmodule // slfc_monitor

bind slfc_core slfc_monitor u_slfc_monitor (.mclk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_enable,
   .frame_irq, .common_pin_oe, .common_pin_addr, .segment_pin_oe,
   .segment_pin_level, .bias_mode, .blank_active);

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [4:0] reg_addr = 5'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg timer_osc_input_pin = 1'b0;
   reg ext_clock_in = 1'b0;
   reg external_clock_input_enable = 1'b0;
   reg global_irq_enable = 1'b0;
   reg irq_ack = 1'b0;
   reg run_ext = 1'b0;
   wire [7:0] reg_rdata;
   wire frame_irq, blank_active, drive_phase;
   wire [3:0] common_pin_oe, common_pin_addr, contrast_level;
   wire [24:0] segment_pin_oe, segment_pin_level;
   wire [1:0] bias_mode;
   wire [2:0] drive_time_sel;
   wire [7:0] frames_seen, bad_drive;
   integer num_errors = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer t1, i;
   // ==========================================
   // Clock, cycle count, external clock source
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   always @(posedge mclk) if (run_ext) ext_clock_in <= ~ext_clock_in;
   slfc_core u_slfc_core (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .timer_osc_input_pin, .ext_clock_in,
      .external_clock_input_enable, .global_irq_enable, .irq_ack,
      .frame_irq, .common_pin_oe, .common_pin_addr, .segment_pin_oe,
      .segment_pin_level, .drive_phase, .bias_mode, .contrast_level,
      .drive_time_sel, .blank_active);
   slfc_glass u_slfc_glass (.mclk, .common_pin_addr, .segment_pin_oe,
      .segment_pin_level, .frames_seen, .bad_drive);
   // ==========================================
   // Tasks
   task test_done;
      begin
         $display("errors=%0d checks=%0d", num_errors, n_checks);
         if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [4:0] a, input [7:0] v);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [4:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata, e);
      end
   endtask
   task wait_irq;
      integer k;
      begin
         k = 0;
         while (frame_irq !== 1'b1 && k < 2000) begin
            @(posedge mclk);
            #1 k = k + 1;
         end
         if (k >= 2000) begin
            chk(32'h0, 32'h1);
            test_done;
         end
      end
   endtask
   task ack;
      begin
         @(posedge mclk);
         irq_ack <= 1'b1;
         @(posedge mclk);
         irq_ack <= 1'b0;
         @(posedge mclk);
         #1 chk(frame_irq, 32'h0);
      end
   endtask
   task gap(input integer exp);
      begin
         wait_irq;
         t1 = cyc;
         ack;
         wait_irq;
         chk(cyc - t1, exp);
         ack;
      end
   endtask
   // ==========================================
   // Scenarios
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(5'h00, 8'h00);
      rd(5'h01, 8'h00);
      rd(5'h04, 8'h00);
      wr(5'h01, 8'hff);
      rd(5'h01, 8'hf7);
      wr(5'h00, 8'h36);
      rd(5'h00, 8'h00);
      wr(5'h00, 8'h80);
      for (i = 0; i < 8; i = i + 1) begin
         wr(5'h01, 8'h30 | i);
         t1 = (i < 6) ? 13 + 2 * i : 18 + i;
         repeat (3) @(posedge mclk);
         #1 chk(segment_pin_oe, (32'h1 << t1) - 1);
      end
      for (i = 0; i < 4; i = i + 1) begin
         wr(5'h01, 8'h47 | (i << 4));
         repeat (3) @(posedge mclk);
         #1 chk(common_pin_oe, (32'h1 << (i + 1)) - 1);
         chk(bias_mode, (i == 0) ? 0 : 2);
      end
      wr(5'h01, 8'h37);
      repeat (3) @(posedge mclk);
      #1 chk(bias_mode, 32'h1);
      wr(5'h02, 8'h00);
      global_irq_enable <= 1'b1;
      wr(5'h00, 8'h98);
      gap(128);
      wr(5'h01, 8'h27);
      gap(96);
      wr(5'h01, 8'h37);
      wr(5'h00, 8'hc8);
      gap(256);
      wr(5'h00, 8'h88);
      gap(128);
      global_irq_enable <= 1'b0;
      repeat (140) @(posedge mclk);
      #1 chk(frame_irq, 32'h0);
      rd(5'h00, 8'h98);
      wr(5'h00, 8'h88);
      rd(5'h00, 8'h98);
      wr(5'h00, 8'h98);
      rd(5'h00, 8'h88);
      global_irq_enable <= 1'b1;
      chk(frames_seen != 8'h00, 32'h1);
      wr(5'h08, 8'h01);
      wait_irq;
      chk(segment_pin_level[1:0] ^ {2{drive_phase}}, 32'h1);
      chk(common_pin_addr, 32'h1);
      ack;
      wr(5'h03, 8'h25);
      wr(5'h00, 8'h99);
      #1 chk(blank_active, 32'h0);
      chk(contrast_level, 32'h0);
      wait_irq;
      repeat (2) @(posedge mclk);
      #1 chk(blank_active, 32'h1);
      chk(segment_pin_level, 32'h0);
      chk(common_pin_addr, 32'h0);
      chk(contrast_level, 32'h5);
      chk(drive_time_sel, 32'h1);
      ack;
      wr(5'h00, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk(common_pin_oe, 32'h0);
      chk(segment_pin_oe, 32'h0);
      chk(bad_drive, 32'h0);
      wr(5'h01, 8'hb7);
      wr(5'h00, 8'h88);
      wait_irq;
      ack;
      repeat (300) @(posedge mclk);
      #1 chk(frame_irq, 32'h0);
      external_clock_input_enable <= 1'b1;
      run_ext <= 1'b1;
      gap(256);
      test_done;
   end
endmodule // tb
